/* design/dis_cfg.svh */
`ifndef DIS_CFG_SVH
`define DIS_CFG_SVH
// register indices as printed; byte address is four times the index
`define DIS_IDX_TIMING 4'h2
`define DIS_IDX_SYNC 4'h3
`define DIS_ADDR_TIMING ({6'h00, `DIS_IDX_TIMING, 2'h0})
`define DIS_ADDR_SYNC ({6'h00, `DIS_IDX_SYNC, 2'h0})
`define DIS_ADDR_SLAVE 12'h010
`define DIS_ADDR_STATUS 12'h014
// timing register fields
`define DIS_T_DLY_HI 15
`define DIS_T_DLY_LO 11
`define DIS_T_MRG_HI 10
`define DIS_T_MRG_LO 7
`define DIS_T_PADSRC 6
`define DIS_T_INV 5
`define DIS_T_DLYEN 4
`define DIS_T_AUTO 3
`define DIS_T_SETHI 2
`define DIS_T_POL 1
`define DIS_T_MASK 32'h0000fffe
`define DIS_T_RESET 32'h00000004
// sync register fields
`define DIS_S_THR_HI 31
`define DIS_S_THR_LO 27
`define DIS_S_RXEN 26
`define DIS_S_TXEN 25
`define DIS_S_MASK 32'hff000000
`define DIS_S_RESET 32'h00000000
// slave mode control register
`define DIS_SL_EN 0
`define DIS_SL_INTERP_HI 2
`define DIS_SL_INTERP_LO 1
`define DIS_SL_MASK 32'h00000007
// delay figures in picoseconds
`define DIS_DLY_MIN_PS 16'd700
`define DIS_DLY_STEP_PS 16'd190
`define DIS_MRG_STEP_PS 16'd190
`define DIS_INTERP_4X 2'h2
`endif

/* design/dis_edge_det.sv */
`timescale 1ns/1ps
// two-flop synchroniser and edge finder for a pin input
module dis_edge_det
	import dis_pkg::*;
(
	// clock
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// pin
	input wire logic pin,
	// edges
	output logic rise,
	output logic fall
);
	dis_edge_st_t st_reg;
	dis_edge_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (ce) begin
			st_next.sync = {st_reg.sync[0], pin};
			st_next.last = st_reg.sync[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// only the second flop feeds the detector
	assign rise = ce & st_reg.sync[1] & ~st_reg.last;
	assign fall = ce & ~st_reg.sync[1] & st_reg.last;
endmodule

/* design/dis_pkg.sv */
package dis_pkg;
	typedef enum logic [1:0] {DIS_IDLE, DIS_ACCESS} dis_apb_st_t;
	typedef struct packed {
		logic [1:0] sync;
		logic last;
	} dis_edge_st_t;
endpackage

/* design/dis_regs.sv */
`timescale 1ns/1ps
`include "dis_cfg.svh"
module dis_regs
	import dis_pkg::*;
#(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal clocks and sync source
	input wire logic sample_clk,
	input wire logic sync_logic_out,
	// data clock output and timing controls
	output logic data_out_clock_src,
	output logic data_out_clock_oe,
	output logic [4:0] clk_delay_code,
	output logic [15:0] clk_delay_ps,
	output logic [3:0] margin_code,
	output logic [15:0] margin_ps,
	output logic auto_timing,
	output logic port_sync_active,
	output logic sync_pad_out,
	// sync controls
	output logic [4:0] corr_threshold,
	output logic sync_rx_en,
	output logic sync_tx_en,
	// slave data path
	input wire logic slave_data_clock_in,
	input wire logic [DW-1:0] slave_din,
	output logic [DW-1:0] slave_dout,
	output logic slave_dvalid
);
	typedef struct packed {
		logic [31:0] timing;
		logic [31:0] sync;
		logic [31:0] slave;
		logic [31:0] rdata;
	} dis_reg_st_t;
	dis_reg_st_t st_reg;
	dis_reg_st_t st_next;
	logic wr_strobe;
	logic rd_strobe;
	logic slave_ok;
	logic dci_rise;
	logic dci_fall;
	logic clk_phase;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `DIS_ADDR_TIMING) || (a == `DIS_ADDR_SYNC) ||
			(a == `DIS_ADDR_SLAVE) || (a == `DIS_ADDR_STATUS);
	endfunction

	assign wr_strobe = ce & psel & penable & pwrite;
	assign rd_strobe = ce & psel & ~penable & ~pwrite;

	// slave mode only honoured with 4x or 8x interpolation
	assign slave_ok = st_reg.slave[`DIS_SL_EN] &
		st_reg.slave[`DIS_SL_INTERP_HI];

	always_comb begin
		st_next = st_reg;
		if (wr_strobe) begin
			// reserved bits dropped by each register's mask; timing bit 0 is reserved
			if (paddr == `DIS_ADDR_TIMING) begin
				st_next.timing = pwdata & `DIS_T_MASK;
			end else if (paddr == `DIS_ADDR_SYNC) begin
				st_next.sync = pwdata & `DIS_S_MASK;
			end else if (paddr == `DIS_ADDR_SLAVE) begin
				st_next.slave = pwdata & `DIS_SL_MASK;
			end
		end else if (rd_strobe) begin
			// read data captured in setup so it comes from a flop
			if (paddr == `DIS_ADDR_TIMING) begin
				st_next.rdata = st_reg.timing;
			end else if (paddr == `DIS_ADDR_SYNC) begin
				st_next.rdata = st_reg.sync;
			end else if (paddr == `DIS_ADDR_SLAVE) begin
				st_next.rdata = st_reg.slave;
			end else if (paddr == `DIS_ADDR_STATUS) begin
				st_next.rdata = {31'h00000000, slave_ok};
			end else begin
				st_next.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.timing <= `DIS_T_RESET;
			st_reg.sync <= `DIS_S_RESET;
			st_reg.slave <= 32'h00000000;
			st_reg.rdata <= 32'h00000000;
		end else begin
			st_reg <= st_next;
		end
	end

	// no wait state: setup, then access with pready high
	assign pready = psel & penable;
	assign prdata = st_reg.rdata;
	// decoded from the live address so it stands with pready
	assign pslverr = psel & penable & ~addr_hit(paddr);

	assign clk_delay_code = st_reg.timing[`DIS_T_DLY_HI:`DIS_T_DLY_LO];
	assign clk_delay_ps = `DIS_DLY_MIN_PS +
		16'(`DIS_DLY_STEP_PS * {11'h000, clk_delay_code});
	assign margin_code = st_reg.timing[`DIS_T_MRG_HI:`DIS_T_MRG_LO];
	assign margin_ps = 16'(`DIS_MRG_STEP_PS * {12'h000, margin_code});
	assign auto_timing = st_reg.timing[`DIS_T_AUTO];
	// the delay line is bypassed while the enable is low
	assign port_sync_active = st_reg.timing[`DIS_T_DLYEN];

	assign clk_phase = sample_clk ^ st_reg.timing[`DIS_T_INV];
	assign data_out_clock_src = clk_phase;
	// pin turns around to an input in slave mode
	assign data_out_clock_oe = ~slave_ok;
	assign sync_pad_out = st_reg.timing[`DIS_T_PADSRC] ?
		clk_phase : sync_logic_out;

	assign corr_threshold = st_reg.sync[`DIS_S_THR_HI:`DIS_S_THR_LO];
	assign sync_rx_en = st_reg.sync[`DIS_S_RXEN];
	assign sync_tx_en = st_reg.sync[`DIS_S_TXEN];

	dis_edge_det i_dis_edge_det (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pin(slave_data_clock_in),
		.rise(dci_rise),
		.fall(dci_fall)
	);

	dis_slave_sampler #(.DW(DW)) i_dis_slave_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.active(slave_ok),
		.rise_sel(st_reg.timing[`DIS_T_POL]),
		.rise(dci_rise),
		.fall(dci_fall),
		.din(slave_din),
		.dout(slave_dout),
		.dvalid(slave_dvalid)
	);

	// register bus: writes land next clock, reserved bits read zero
	a_write_timing_sticks: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_TIMING |=>
		st_reg.timing == ($past(pwdata) & `DIS_T_MASK))
		else $error("timing register write lost");
	a_write_sync_sticks: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_SYNC |=>
		st_reg.sync == ($past(pwdata) & `DIS_S_MASK))
		else $error("sync register write lost");
	a_write_slave_sticks: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_SLAVE |=>
		st_reg.slave == ($past(pwdata) & `DIS_SL_MASK))
		else $error("slave control write lost");
	a_reserved_reads_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st_reg.timing & ~`DIS_T_MASK) == 32'h00000000)
		else $error("reserved timing bits set");
	a_unmapped_write_drop: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && !addr_hit(paddr) |=>
		$stable(st_reg.timing) && $stable(st_reg.sync) &&
		$stable(st_reg.slave))
		else $error("unmapped write changed a register");
	a_answer_in_access: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable |->
		pready && (pslverr == !addr_hit(paddr)))
		else $error("bus answer wrong in access");
	a_read_capture: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_strobe && paddr == `DIS_ADDR_TIMING |=>
		prdata == $past(st_reg.timing))
		else $error("timing read data wrong");
	a_frozen_by_ce: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ce |=>
		$stable(st_reg))
		else $error("state moved while clock enable low");

	// data clock and timing controls
	a_delay_code_field: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_TIMING |=>
		clk_delay_code == $past(pwdata[`DIS_T_DLY_HI:`DIS_T_DLY_LO]))
		else $error("delay code not updated");
	a_delay_step_size: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_delay_ps ==
		`DIS_DLY_MIN_PS + 16'(`DIS_DLY_STEP_PS * clk_delay_code))
		else $error("delay step wrong");
	a_margin_code_field: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_TIMING |=>
		margin_code == $past(pwdata[`DIS_T_MRG_HI:`DIS_T_MRG_LO]))
		else $error("margin code not updated");
	a_margin_step_size: assert property (
		@(posedge pclk) disable iff (!presetn)
		margin_ps ==
		16'(`DIS_MRG_STEP_PS * margin_code))
		else $error("margin step wrong");
	a_pad_src_sync: assert property (
		@(posedge pclk) disable iff (!presetn)
		!st_reg.timing[`DIS_T_PADSRC] |->
		sync_pad_out == sync_logic_out)
		else $error("sync pad not from sync logic");
	a_pad_src_clk: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.timing[`DIS_T_PADSRC] |->
		sync_pad_out == data_out_clock_src)
		else $error("sync pad not from data clock");
	a_clock_invert: assert property (
		@(posedge pclk) disable iff (!presetn)
		data_out_clock_src ==
		(sample_clk ^ st_reg.timing[`DIS_T_INV]))
		else $error("data clock phase wrong");
	a_delay_bypass: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_TIMING |=>
		port_sync_active == $past(pwdata[`DIS_T_DLYEN]))
		else $error("delay enable not updated");
	a_timing_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_TIMING |=>
		auto_timing == $past(pwdata[`DIS_T_AUTO]))
		else $error("timing mode not updated");

	// multichip sync controls
	a_threshold_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_SYNC |=>
		corr_threshold == $past(pwdata[`DIS_S_THR_HI:`DIS_S_THR_LO]))
		else $error("threshold not updated");
	a_sync_rx_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_SYNC |=>
		sync_rx_en == $past(pwdata[`DIS_S_RXEN]))
		else $error("sync receive enable not updated");
	a_sync_tx_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == `DIS_ADDR_SYNC |=>
		sync_tx_en == $past(pwdata[`DIS_S_TXEN]))
		else $error("sync transmit enable not updated");
	a_sync_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st_reg.sync & ~`DIS_S_MASK) == 32'h00000000)
		else $error("omitted sync bits set");

	// slave sampling on the chosen edge only
	a_slave_fall_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && slave_ok && !st_reg.timing[`DIS_T_POL] && dci_fall |=>
		slave_dvalid)
		else $error("falling edge sample missed");
	a_slave_rise_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && slave_ok && st_reg.timing[`DIS_T_POL] && dci_rise |=>
		slave_dvalid)
		else $error("rising edge sample missed");
	a_slave_wrong_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && (!slave_ok ||
		(st_reg.timing[`DIS_T_POL] ? !dci_rise : !dci_fall)) |=>
		!slave_dvalid)
		else $error("sample taken on wrong edge");
	a_slave_needs_interp: assert property (
		@(posedge pclk) disable iff (!presetn)
		!st_reg.slave[`DIS_SL_INTERP_HI] |=>
		!slave_dvalid)
		else $error("slave sample without 4x or 8x");
	a_oe_follows_slave: assert property (
		@(posedge pclk) disable iff (!presetn)
		data_out_clock_oe ==
		!(st_reg.slave[`DIS_SL_EN] && st_reg.slave[`DIS_SL_INTERP_HI]))
		else $error("data clock pin direction wrong");
endmodule

/* design/dis_slave_sampler.sv */
`timescale 1ns/1ps
// captures input data on the chosen edge of the incoming data clock
module dis_slave_sampler
	import dis_pkg::*;
#(
	parameter int DW = 16
) (
	// clock
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic active,
	input wire logic rise_sel,
	input wire logic rise,
	input wire logic fall,
	// data
	input wire logic [DW-1:0] din,
	output logic [DW-1:0] dout,
	output logic dvalid
);
	typedef struct packed {
		logic [1:0][DW-1:0] sync;
		logic [DW-1:0] data;
		logic valid;
	} dis_smp_st_t;
	dis_smp_st_t st_reg;
	dis_smp_st_t st_next;
	logic hit;

	always_comb begin
		hit = active & (rise_sel ? rise : fall);
		st_next = st_reg;
		if (ce) begin
			// data delayed the same two stages as the clock
			st_next.sync[0] = din;
			st_next.sync[1] = st_reg.sync[0];
			st_next.valid = hit;
			if (hit) begin
				st_next.data = st_reg.sync[1];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.data;
	assign dvalid = st_reg.valid;
endmodule

/* verification/data_input_sync_control_regs_test.sv */
`timescale 1ns/1ps
`include "dis_cfg.svh"
module data_input_sync_control_regs_test
	import dis_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, go = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sclk = 1'b0, slo = 1'b0, src, oe, pad;
	logic autot, psa, rxen, txen, dclk, dval;
	logic [4:0] dcode, thr;
	logic [3:0] mcode;
	logic [15:0] dps, mps, din, dout;
	logic [15:0] base = 16'h3c00;
	int num_errors = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	dis_regs i_dis_regs (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_clk(sclk), .sync_logic_out(slo),
		.data_out_clock_src(src), .data_out_clock_oe(oe),
		.clk_delay_code(dcode), .clk_delay_ps(dps), .margin_code(mcode),
		.margin_ps(mps), .auto_timing(autot), .port_sync_active(psa),
		.sync_pad_out(pad), .corr_threshold(thr), .sync_rx_en(rxen),
		.sync_tx_en(txen), .slave_data_clock_in(dclk), .slave_din(din),
		.slave_dout(dout), .slave_dvalid(dval));
	dis_src_model i_dis_src_model (.go(go), .base(base), .dclk(dclk),
		.dout(din));
	task automatic give_verdict();
		if (num_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic t_reset();
		apb(0, `DIS_ADDR_TIMING, 0);
		chk("timing", rd, 32'h4);
		apb(0, `DIS_ADDR_SYNC, 0);
		chk("sync", rd, 32'h0);
		chk("rx", rxen, 0);
		chk("tx", txen, 0);
		chk("psa", psa, 0);
		chk("src", src, sclk);
		chk("pad", pad, slo);
		chk("oe", oe, 1);
	endtask
	task automatic t_fields();
		logic [31:0] v;
		for (int i = 0; i < 32; i++) begin
			v = (i << 11) | ((i & 15) << 7) | 4 | ((i & 3) << 3);
			apb(1, `DIS_ADDR_TIMING, v);
			chk("code", dcode, i);
			chk("dps", dps, 700 + 190 * i);
			chk("mcode", mcode, i & 15);
			chk("mps", mps, 190 * (i & 15));
			chk("auto", autot, i & 1);
			chk("psa", psa, (i >> 1) & 1);
			apb(0, `DIS_ADDR_TIMING, 0);
			chk("rdback", rd, v);
		end
		apb(1, `DIS_ADDR_TIMING, 32'hffffffff);
		apb(0, `DIS_ADDR_TIMING, 0);
		chk("rsvd", rd, 32'h0000fffe);
	endtask
	task automatic t_mux();
		logic [2:0] b;
		for (int i = 0; i < 8; i++) begin
			b = i[2:0];
			apb(1, `DIS_ADDR_TIMING, 4 | (b[0] << 5) | (b[1] << 6));
			@(posedge pclk);
			sclk <= b[2];
			slo <= !b[2];
			@(posedge pclk);
			#1;
			chk("src", src, b[2] ^ b[0]);
			chk("pad", pad, b[1] ? (b[2] ^ b[0]) : !b[2]);
		end
	endtask
	task automatic t_sync();
		logic [31:0] v;
		for (int i = 0; i < 2; i++) begin
			v = i ? 32'h5a000000 : 32'hfeffffff;
			apb(1, `DIS_ADDR_SYNC, v);
			chk("thr", thr, v[31:27]);
			chk("rx", rxen, v[26]);
			chk("tx", txen, v[25]);
			apb(0, `DIS_ADDR_SYNC, 0);
			chk("sync", rd, v & 32'hff000000);
		end
	endtask
	task automatic t_unmapped();
		apb(1, 12'h020, 32'hffffffff);
		chk("werr", err, 1);
		apb(0, 12'h020, 0);
		chk("rerr", err, 1);
		chk("rdata", rd, 0);
	endtask
	task automatic t_ce();
		apb(1, `DIS_ADDR_TIMING, 32'h0000f804);
		@(posedge pclk);
		ce <= 1'b0;
		apb(1, `DIS_ADDR_TIMING, 32'h00000004);
		chk("frozen", dcode, 5'h1f);
		@(posedge pclk);
		ce <= 1'b1;
		apb(0, `DIS_ADDR_TIMING, 0);
		chk("kept", rd, 32'h0000f804);
	endtask
	task automatic t_slave(input logic pol, input logic [31:0] ctl,
		input int en);
		int n;
		apb(1, `DIS_ADDR_TIMING, 4 | (pol << 1));
		apb(1, `DIS_ADDR_SLAVE, ctl);
		chk("oe", oe, en == 0);
		apb(0, `DIS_ADDR_STATUS, 0);
		chk("stat", rd[0], en != 0);
		@(posedge pclk);
		go <= 1'b1;
		n = 0;
		repeat (100) begin
			@(posedge pclk);
			#1;
			if (dval === 1'b1) begin
				chk("dout", dout, base + n + (pol ? 0 : 16'h0100));
				n++;
			end
		end
		go <= 1'b0;
		chk("count", n, en ? 4 : 0);
		apb(1, `DIS_ADDR_SLAVE, 0);
	endtask
	initial begin
		#500000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_mux();
		t_sync();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ce();
		t_unmapped();
		t_slave(1, 32'h5, 1);
		t_slave(0, 32'h7, 1);
		t_slave(1, 32'h3, 0);
		t_slave(0, 32'h4, 0);
		give_verdict();
	end
endmodule

/* verification/dis_src_model.sv */
`timescale 1ns/1ps
// far-side word source clocking data into the slave port
module dis_src_model
	import dis_pkg::*;
(
	// control
	input wire logic go,
	input wire logic [15:0] base,
	// link
	output logic dclk,
	output logic [15:0] dout
);
	logic busy;
	initial begin
		dclk = 1'b0;
		dout = 16'h0000;
		busy = 1'b0;
	end
	// idle data churns so stale values never pass for a sample
	always #20 if (!busy) dout = ~dout;
	// rise sees base+k, fall sees base+k+0x100, 40 ns each side
	always @(posedge go) begin
		busy = 1'b1;
		for (int k = 0; k < 4; k++) begin
			dout = base + 16'(k);
			#40 dclk = 1'b1;
			#40 dout = base + 16'(k) + 16'h0100;
			#40 dclk = 1'b0;
			#40;
		end
		busy = 1'b0;
	end
endmodule
